//--- hdl/tcc_defines.vh
/*
 Register offsets, field positions and reset values for the timer capture
 channel configuration block. Assumes a 32-bit APB master with word-aligned
 accesses.
*/
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

`define TCC_ADDR_W 8
`define TCC_OFF_STATUS 8'h10
`define TCC_OFF_CH1_MODE 8'h18
`define TCC_OFF_CH34_MODE 8'h1c
`define TCC_OFF_ENPOL 8'h20
`define TCC_OFF_CH1_CAPT 8'h34
`define TCC_OFF_CH3_CAPT 8'h3c
`define TCC_OFF_CH4_CAPT 8'h40

`define TCC_ENPOL_RESET 16'h0000
`define TCC_ENPOL_MASK 16'hbbbb
`define TCC_CH34_RESET 16'h0000
`define TCC_CH1_MODE_RESET 2'h0
`define TCC_STATUS_W 6

// Enable and polarity register fields
`define TCC_CH1_EN 0
`define TCC_CH1_POL 1
`define TCC_CH1_NPOL 3
`define TCC_CH3_EN 8
`define TCC_CH3_POL 9
`define TCC_CH3_NPOL 11
`define TCC_CH4_EN 12
`define TCC_CH4_POL 13
`define TCC_CH4_NPOL 15

// Channel 3/4 input mode fields
`define TCC_CH3_SEL_HI 1
`define TCC_CH3_SEL_LO 0
`define TCC_CH3_PSC_HI 3
`define TCC_CH3_PSC_LO 2
`define TCC_CH3_FLT_HI 7
`define TCC_CH3_FLT_LO 4
`define TCC_CH4_SEL_HI 9
`define TCC_CH4_SEL_LO 8
`define TCC_CH4_PSC_HI 11
`define TCC_CH4_PSC_LO 10
`define TCC_CH4_FLT_HI 15
`define TCC_CH4_FLT_LO 12

// Direction encodings
`define TCC_SEL_OUTPUT 2'h0
`define TCC_SEL_OWN 2'h1
`define TCC_SEL_OTHER 2'h2
`define TCC_SEL_TRIGGER 2'h3

// Polarity pair encodings, {complement, polarity}
`define TCC_POL_RISE 2'h0
`define TCC_POL_FALL 2'h1
`define TCC_POL_RESERVED 2'h2
`define TCC_POL_BOTH 2'h3

// Status flag positions
`define TCC_ST_CH1_CAPT 0
`define TCC_ST_CH3_CAPT 1
`define TCC_ST_CH4_CAPT 2
`define TCC_ST_CH1_OVER 3
`define TCC_ST_CH3_OVER 4
`define TCC_ST_CH4_OVER 5

`define TCC_FILTER_BYPASS 4'h0

`endif

//--- hdl/tcc_input_filter.v
/*
 Digital input filter: samples at the clock divided by a coded divider and
 accepts a new level only after N equal samples. Input is synchronous to pclk.
*/
`timescale 1ns/1ps
module tcc_input_filter (
  pclk,
  presetn,
  filter_code,
  din,
  level
);
  input wire pclk;
  input wire presetn;
  input wire [3:0] filter_code;
  input wire din;
  output reg level;

  reg [4:0] div_cnt;
  reg sample_tick;
  reg [3:0] match_cnt;
  reg [4:0] div_last;
  reg [3:0] need;

  // Divider minus one and sample count for each code
  function [8:0] filter_table;
    input [3:0] code;
    begin
      case (code)
        4'h0: filter_table = {5'h00, 4'h1};
        4'h1: filter_table = {5'h00, 4'h2};
        4'h2: filter_table = {5'h00, 4'h4};
        4'h3: filter_table = {5'h00, 4'h8};
        4'h4: filter_table = {5'h01, 4'h6};
        4'h5: filter_table = {5'h01, 4'h8};
        4'h6: filter_table = {5'h03, 4'h6};
        4'h7: filter_table = {5'h03, 4'h8};
        4'h8: filter_table = {5'h07, 4'h6};
        4'h9: filter_table = {5'h07, 4'h8};
        4'ha: filter_table = {5'h0f, 4'h5};
        4'hb: filter_table = {5'h0f, 4'h6};
        4'hc: filter_table = {5'h0f, 4'h8};
        4'hd: filter_table = {5'h1f, 4'h5};
        4'he: filter_table = {5'h1f, 4'h6};
        default: filter_table = {5'h1f, 4'h8};
      endcase
    end
  endfunction

  always @* begin
    {div_last, need} = filter_table(filter_code);
  end

  // Sample rate enable pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 5'h00;
      sample_tick <= 1'b0;
    end else if (div_cnt >= div_last) begin
      div_cnt <= 5'h00;
      sample_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 5'h01;
      sample_tick <= 1'b0;
    end
  end

  // A glitch shorter than N samples restarts the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      match_cnt <= 4'h0;
    end else if (sample_tick) begin
      if (din == level) begin
        match_cnt <= 4'h0;
      end else if (match_cnt + 4'h1 >= need) begin
        level <= din;
        match_cnt <= 4'h0;
      end else begin
        match_cnt <= match_cnt + 4'h1;
      end
    end
  end
endmodule // tcc_input_filter

//--- hdl/tcc_capture_prescale.v
/*
 Capture event prescaler: passes one event in every 1, 2, 4 or 8.
 Events are single-cycle pulses on pclk.
*/
`timescale 1ns/1ps
module tcc_capture_prescale (
  pclk,
  presetn,
  clear,
  psc_code,
  event_in,
  capture
);
  input wire pclk;
  input wire presetn;
  input wire clear;
  input wire [1:0] psc_code;
  input wire event_in;
  output reg capture;

  reg [2:0] cnt;
  wire [2:0] last;

  assign last = (3'h1 << psc_code) - 3'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      capture <= 1'b0;
    end else if (clear) begin
      cnt <= 3'h0;
      capture <= 1'b0;
    end else if (event_in) begin
      capture <= (cnt >= last);
      cnt <= (cnt >= last) ? 3'h0 : cnt + 3'h1;
    end else begin
      capture <= 1'b0;
    end
  end
endmodule // tcc_capture_prescale

//--- hdl/tcc_channel_config.v
/*
 Timer capture channel configuration: APB registers, input selection,
 filtering, polarity, prescaling and capture for channels 3 and 4, and the
 enable/polarity view of channel 1 with its capture and output.
 Assumes timer inputs and the counter value are synchronous to pclk and that
 the compare logic outside supplies the reference levels.
*/
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_channel_config #(
  parameter CNT_W = 16
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  timer_input_one,
  timer_input_three,
  timer_input_four,
  internal_trigger_source,
  internal_trigger_selected,
  counter_value,
  ref_level_one,
  ref_level_three,
  ref_level_four,
  channel_one_output,
  channel_one_output_en,
  channel_three_output,
  channel_three_output_en,
  channel_four_output,
  channel_four_output_en,
  filtered_input_one_path_one,
  capture_input_three,
  capture_input_four,
  capture_event_one,
  capture_event_three,
  capture_event_four
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [`TCC_ADDR_W-1:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire timer_input_one;
  input wire timer_input_three;
  input wire timer_input_four;
  input wire internal_trigger_source;
  input wire internal_trigger_selected;
  input wire [CNT_W-1:0] counter_value;
  input wire ref_level_one;
  input wire ref_level_three;
  input wire ref_level_four;
  output reg channel_one_output;
  output reg channel_one_output_en;
  output reg channel_three_output;
  output reg channel_three_output_en;
  output reg channel_four_output;
  output reg channel_four_output_en;
  output reg filtered_input_one_path_one;
  output reg capture_input_three;
  output reg capture_input_four;
  output reg capture_event_one;
  output reg capture_event_three;
  output reg capture_event_four;

  reg [15:0] capture_enable_polarity;
  reg [15:0] channel34_input_mode;
  reg [1:0] ch1_direction_select;
  reg [`TCC_STATUS_W-1:0] capture_status;
  reg [CNT_W-1:0] channel_one_capture_value;
  reg [CNT_W-1:0] channel_three_capture_value;
  reg [CNT_W-1:0] channel_four_capture_value;
  reg next_ch3_raw;
  reg next_ch4_raw;
  reg next_ch3_live;
  reg next_ch4_live;
  reg [15:0] next_mode;
  reg [`TCC_STATUS_W-1:0] next_status;
  reg [`TCC_STATUS_W-1:0] set_status;
  reg [31:0] next_rdata;
  reg next_err;
  reg prev_one;
  reg prev_three;
  reg prev_four;

  wire setup_phase;
  wire write_access;
  wire ch1_enable;
  wire ch3_enable;
  wire ch4_enable;
  wire [1:0] ch1_pol_pair;
  wire [1:0] ch3_pol_pair;
  wire [1:0] ch4_pol_pair;
  wire [1:0] ch3_direction_select;
  wire [1:0] ch4_direction_select;
  wire [1:0] ch3_capture_prescale;
  wire [1:0] ch4_capture_prescale;
  wire [3:0] ch3_input_filter;
  wire [3:0] ch4_input_filter;
  wire level_one;
  wire level_three;
  wire level_four;
  wire edge_one;
  wire edge_three;
  wire edge_four;
  wire ch1_is_input;
  wire ch3_is_input;
  wire ch4_is_input;
  wire cap3;
  wire cap4;

  // Edge qualification by polarity pair
  function edge_hit;
    input prev;
    input cur;
    input [1:0] pair;
    begin
      case (pair)
        `TCC_POL_FALL: edge_hit = prev & ~cur;
        `TCC_POL_BOTH: edge_hit = prev ^ cur;
        default: edge_hit = ~prev & cur;
      endcase
    end
  endfunction

  // Level seen by gated and encoder modes
  function polarize;
    input lvl;
    input [1:0] pair;
    begin
      polarize = (pair == `TCC_POL_FALL) ? ~lvl : lvl;
    end
  endfunction

  // Output pin value for a channel
  function out_level;
    input en;
    input ref_lvl;
    input pol;
    begin
      out_level = en & (ref_lvl ^ pol);
    end
  endfunction

  assign setup_phase = psel & ~penable;
  assign write_access = psel & penable & pready & pwrite;

  assign ch1_enable = capture_enable_polarity[`TCC_CH1_EN];
  assign ch3_enable = capture_enable_polarity[`TCC_CH3_EN];
  assign ch4_enable = capture_enable_polarity[`TCC_CH4_EN];
  // Pair formed from both polarity bits
  assign ch1_pol_pair = {capture_enable_polarity[`TCC_CH1_NPOL],
                         capture_enable_polarity[`TCC_CH1_POL]};
  assign ch3_pol_pair = {capture_enable_polarity[`TCC_CH3_NPOL],
                         capture_enable_polarity[`TCC_CH3_POL]};
  assign ch4_pol_pair = {capture_enable_polarity[`TCC_CH4_NPOL],
                         capture_enable_polarity[`TCC_CH4_POL]};

  assign ch3_direction_select = channel34_input_mode[`TCC_CH3_SEL_HI:`TCC_CH3_SEL_LO];
  assign ch4_direction_select = channel34_input_mode[`TCC_CH4_SEL_HI:`TCC_CH4_SEL_LO];
  assign ch3_capture_prescale = channel34_input_mode[`TCC_CH3_PSC_HI:`TCC_CH3_PSC_LO];
  assign ch4_capture_prescale = channel34_input_mode[`TCC_CH4_PSC_HI:`TCC_CH4_PSC_LO];
  assign ch3_input_filter = channel34_input_mode[`TCC_CH3_FLT_HI:`TCC_CH3_FLT_LO];
  assign ch4_input_filter = channel34_input_mode[`TCC_CH4_FLT_HI:`TCC_CH4_FLT_LO];

  assign ch1_is_input = (ch1_direction_select != `TCC_SEL_OUTPUT);
  assign ch3_is_input = (ch3_direction_select != `TCC_SEL_OUTPUT);
  assign ch4_is_input = (ch4_direction_select != `TCC_SEL_OUTPUT);

  // Input source selection before the filter
  always @* begin
    next_ch3_raw = 1'b0;
    next_ch4_raw = 1'b0;
    next_ch3_live = 1'b1;
    next_ch4_live = 1'b1;
    case (ch3_direction_select)
      `TCC_SEL_OWN: next_ch3_raw = timer_input_three;
      `TCC_SEL_OTHER: next_ch3_raw = timer_input_four;
      `TCC_SEL_TRIGGER: begin
        next_ch3_raw = internal_trigger_source;
        next_ch3_live = internal_trigger_selected;
      end
      default: next_ch3_live = 1'b0;
    endcase
    case (ch4_direction_select)
      `TCC_SEL_OWN: next_ch4_raw = timer_input_four;
      `TCC_SEL_OTHER: next_ch4_raw = timer_input_three;
      // Trigger source only with internal trigger
      `TCC_SEL_TRIGGER: begin
        next_ch4_raw = internal_trigger_source;
        next_ch4_live = internal_trigger_selected;
      end
      default: next_ch4_live = 1'b0;
    endcase
  end

  tcc_input_filter u_filter_one (
    .pclk(pclk),
    .presetn(presetn),
    .filter_code(`TCC_FILTER_BYPASS),
    .din(timer_input_one),
    .level(level_one)
  );

  tcc_input_filter u_filter_three (
    .pclk(pclk),
    .presetn(presetn),
    .filter_code(ch3_input_filter),
    .din(next_ch3_raw),
    .level(level_three)
  );

  tcc_input_filter u_filter_four (
    .pclk(pclk),
    .presetn(presetn),
    .filter_code(ch4_input_filter),
    .din(next_ch4_raw),
    .level(level_four)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_one <= 1'b0;
      prev_three <= 1'b0;
      prev_four <= 1'b0;
    end else begin
      prev_one <= level_one;
      prev_three <= level_three;
      prev_four <= level_four;
    end
  end

  assign edge_one = edge_hit(prev_one, level_one, ch1_pol_pair);
  assign edge_three = edge_hit(prev_three, level_three, ch3_pol_pair) & next_ch3_live;
  assign edge_four = edge_hit(prev_four, level_four, ch4_pol_pair) & next_ch4_live;

  // Ch3 prescaler, cleared while capture is off
  tcc_capture_prescale u_psc_three (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~(ch3_enable & ch3_is_input)),
    .psc_code(ch3_capture_prescale),
    .event_in(edge_three),
    .capture(cap3)
  );

  tcc_capture_prescale u_psc_four (
    .pclk(pclk),
    .presetn(presetn),
    .clear(~(ch4_enable & ch4_is_input)),
    .psc_code(ch4_capture_prescale),
    .event_in(edge_four),
    .capture(cap4)
  );

  // Capture registers and event pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_one_capture_value <= {CNT_W{1'b0}};
      channel_three_capture_value <= {CNT_W{1'b0}};
      channel_four_capture_value <= {CNT_W{1'b0}};
      capture_event_one <= 1'b0;
      capture_event_three <= 1'b0;
      capture_event_four <= 1'b0;
    end else begin
      capture_event_one <= edge_one & ch1_enable & ch1_is_input;
      capture_event_three <= cap3;
      capture_event_four <= cap4;
      if (edge_one & ch1_enable & ch1_is_input) begin
        channel_one_capture_value <= counter_value;
      end
      if (cap3) begin
        channel_three_capture_value <= counter_value;
      end
      if (cap4) begin
        channel_four_capture_value <= counter_value;
      end
    end
  end

  // Sticky flags: a new capture beats a software clear in the same cycle
  always @* begin
    set_status = {`TCC_STATUS_W{1'b0}};
    set_status[`TCC_ST_CH1_CAPT] = capture_event_one;
    set_status[`TCC_ST_CH3_CAPT] = capture_event_three;
    set_status[`TCC_ST_CH4_CAPT] = capture_event_four;
    set_status[`TCC_ST_CH1_OVER] = capture_event_one & capture_status[`TCC_ST_CH1_CAPT];
    set_status[`TCC_ST_CH3_OVER] = capture_event_three & capture_status[`TCC_ST_CH3_CAPT];
    set_status[`TCC_ST_CH4_OVER] = capture_event_four & capture_status[`TCC_ST_CH4_CAPT];
    next_status = capture_status;
    if (write_access && paddr == `TCC_OFF_STATUS) begin
      next_status = capture_status & pwdata[`TCC_STATUS_W-1:0];
    end
    next_status = next_status | set_status;
  end

  // Protected direction fields in the channel 3/4 mode word
  always @* begin
    next_mode = pwdata[15:0];
    if (ch3_enable) begin
      next_mode[`TCC_CH3_SEL_HI:`TCC_CH3_SEL_LO] = ch3_direction_select;
    end
    if (ch4_enable) begin
      next_mode[`TCC_CH4_SEL_HI:`TCC_CH4_SEL_LO] = ch4_direction_select;
    end
  end

  // Register writes, taken at the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_enable_polarity <= `TCC_ENPOL_RESET;
      channel34_input_mode <= `TCC_CH34_RESET;
      ch1_direction_select <= `TCC_CH1_MODE_RESET;
      capture_status <= {`TCC_STATUS_W{1'b0}};
    end else begin
      capture_status <= next_status;
      if (write_access) begin
        if (paddr == `TCC_OFF_ENPOL) begin
          capture_enable_polarity <= pwdata[15:0] & `TCC_ENPOL_MASK;
        end else if (paddr == `TCC_OFF_CH34_MODE) begin
          channel34_input_mode <= next_mode;
        end else if (paddr == `TCC_OFF_CH1_MODE) begin
          if (!ch1_enable) begin
            ch1_direction_select <= pwdata[1:0];
          end
        end
      end
    end
  end

  // Read data and error decided in the setup cycle
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == `TCC_OFF_ENPOL) begin
      next_rdata[15:0] = capture_enable_polarity;
    end else if (paddr == `TCC_OFF_CH34_MODE) begin
      next_rdata[15:0] = channel34_input_mode;
    end else if (paddr == `TCC_OFF_CH1_MODE) begin
      next_rdata[1:0] = ch1_direction_select;
    end else if (paddr == `TCC_OFF_STATUS) begin
      next_rdata[`TCC_STATUS_W-1:0] = capture_status;
    end else if (paddr == `TCC_OFF_CH1_CAPT) begin
      next_rdata[CNT_W-1:0] = channel_one_capture_value;
    end else if (paddr == `TCC_OFF_CH3_CAPT) begin
      next_rdata[CNT_W-1:0] = channel_three_capture_value;
    end else if (paddr == `TCC_OFF_CH4_CAPT) begin
      next_rdata[CNT_W-1:0] = channel_four_capture_value;
    end else begin
      next_err = 1'b1;
    end
  end

  // Zero wait states; data registered so it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else if (!psel) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Channel pins and polarized input levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_one_output <= 1'b0;
      channel_one_output_en <= 1'b0;
      channel_three_output <= 1'b0;
      channel_three_output_en <= 1'b0;
      channel_four_output <= 1'b0;
      channel_four_output_en <= 1'b0;
      filtered_input_one_path_one <= 1'b0;
      capture_input_three <= 1'b0;
      capture_input_four <= 1'b0;
    end else begin
      channel_one_output_en <= ch1_enable & ~ch1_is_input;
      // Polarity bit high makes output active low
      channel_one_output <= out_level(ch1_enable & ~ch1_is_input, ref_level_one,
                                      capture_enable_polarity[`TCC_CH1_POL]);
      channel_three_output_en <= ch3_enable & ~ch3_is_input;
      channel_three_output <= out_level(ch3_enable & ~ch3_is_input, ref_level_three,
                                        capture_enable_polarity[`TCC_CH3_POL]);
      channel_four_output_en <= ch4_enable & ~ch4_is_input;
      channel_four_output <= out_level(ch4_enable & ~ch4_is_input, ref_level_four,
                                       capture_enable_polarity[`TCC_CH4_POL]);
      filtered_input_one_path_one <= polarize(level_one, ch1_pol_pair);
      capture_input_three <= polarize(level_three, ch3_pol_pair);
      capture_input_four <= polarize(level_four, ch4_pol_pair);
    end
  end
endmodule // tcc_channel_config

//--- testbench/tcc_channel_config_sva.sv
/* Port assertions for tcc_channel_config.
   Assumes the single pclk domain and active-low presetn. */
`timescale 1ns/1ps
module tcc_channel_config_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire ref_level_one,
  input wire channel_one_output,
  input wire channel_one_output_en,
  input wire channel_three_output,
  input wire channel_three_output_en,
  input wire channel_four_output,
  input wire channel_four_output_en,
  input wire capture_event_three,
  input wire capture_event_four
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg ref_d;
  wire mapped = paddr inside {8'h10, 8'h18, 8'h1c, 8'h20, 8'h34, 8'h3c, 8'h40};
  // Output is registered, so compare it with last cycle's reference
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ref_d <= 1'b0;
    else ref_d <= ref_level_one;
  end
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_ERR_MAPPED: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on a mapped address");
  AST_ERR_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on an unmapped address");
  AST_CH1_OFF: assert property (!channel_one_output_en |-> !channel_one_output)
    else $error("disabled channel one output not zero");
  AST_CH3_OFF: assert property (!channel_three_output_en |-> !channel_three_output)
    else $error("disabled channel three output not zero");
  AST_CH4_OFF: assert property (!channel_four_output_en |-> !channel_four_output)
    else $error("disabled channel four output not zero");
  AST_CH1_TRACK: assert property ((channel_one_output_en && !psel) [*3] |->
    $stable(channel_one_output ^ ref_d))
    else $error("channel one output does not follow reference");
  AST_CH3_NO_CAPT: assert property (channel_three_output_en |-> !capture_event_three)
    else $error("capture on channel three in output mode");
  AST_CH4_NO_CAPT: assert property (channel_four_output_en |-> !capture_event_four)
    else $error("capture on channel four in output mode");
endmodule // tcc_channel_config_sva
bind tcc_channel_config tcc_channel_config_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .ref_level_one(ref_level_one), .channel_one_output(channel_one_output),
  .channel_one_output_en(channel_one_output_en), .channel_three_output(channel_three_output),
  .channel_three_output_en(channel_three_output_en), .channel_four_output(channel_four_output),
  .channel_four_output_en(channel_four_output_en), .capture_event_three(capture_event_three),
  .capture_event_four(capture_event_four));

//--- testbench/tcc_channel_config_test.sv
/* Self-checking APB bench for tcc_channel_config.
   Assumes timer inputs synchronous to pclk and filter code 0 on fast paths. */
`timescale 1ns/1ps
module tcc_channel_config_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trig = 0, r1 = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0;
  reg [3:0] tin = 0;
  reg [15:0] cnt = 0;
  wire [31:0] prdata;
  wire pready, pslverr, o1, oe1, e1, e3, e4, ci3, ci4, fp1;
  logic [31:0] q;
  logic err;
  int errors = 0, checks = 0, ev1, ev3, ev4;
  logic [15:0] tm[7] = '{16'h0101, 16'h0101, 16'h0202, 16'h0303, 16'h0303, 16'h01f1, 16'hf101};
  int ti[7] = '{1, 2, 1, 3, 3, 1, 2};
  bit tt[7] = '{0, 0, 0, 0, 1, 0, 0};
  int x3[7] = '{3, 0, 0, 0, 3, 0, 0};
  int x4[7] = '{0, 3, 3, 0, 3, 0, 0};
  logic [15:0] pe[3] = '{16'h0100, 16'h0300, 16'h0b00};
  int xr[3] = '{1, 0, 1};
  int xd[3] = '{1, 1, 2};
  logic [31:0] en1[4] = '{0, 1, 3, 3};
  bit rf[4] = '{1, 1, 1, 0};
  logic [1:0] xo[4] = '{2'b00, 2'b11, 2'b10, 2'b11};
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    ev1 += (e1 === 1'b1);
    ev3 += (e3 === 1'b1);
    ev4 += (e4 === 1'b1);
  end
  tcc_channel_config u_tcc_channel_config (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_one(tin[0]), .timer_input_three(tin[1]),
    .timer_input_four(tin[2]), .internal_trigger_source(tin[3]),
    .internal_trigger_selected(trig), .counter_value(cnt), .ref_level_one(r1),
    .ref_level_three(r1), .ref_level_four(r1), .channel_one_output(o1),
    .channel_one_output_en(oe1), .channel_three_output(), .channel_three_output_en(),
    .channel_four_output(), .channel_four_output_en(), .filtered_input_one_path_one(fp1),
    .capture_input_three(ci3), .capture_input_four(ci4), .capture_event_one(e1),
    .capture_event_three(e3), .capture_event_four(e4));
  task give_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One idle edge first, so back-to-back calls never drive psel twice in a step
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Request held until ready is seen; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Settle after enabling so a stray edge from the polarity change is not counted
  task cfg(input logic [15:0] m, input logic [15:0] en, input bit t);
    xf(1, 8'h20, 0);
    xf(1, 8'h1c, {16'h0, m});
    trig <= t;
    xf(1, 8'h20, {16'h0, en});
    repeat (8) @(posedge pclk);
    ev1 = 0;
    ev3 = 0;
    ev4 = 0;
  endtask
  task pul(input int i, input int n);
    repeat (n) begin
      @(posedge pclk);
      tin[i] <= 1;
      repeat (6) @(posedge pclk);
      tin[i] <= 0;
      repeat (6) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    #200000;
    errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    xf(0, 8'h20, 0);
    chk("enpol", 0, q);
    xf(0, 8'h1c, 0);
    chk("mode34", 0, q);
    xf(1, 8'h20, 32'hffff);
    xf(0, 8'h20, 0);
    chk("enpol", 32'hbbbb, q);
    cfg(16'h5aa5, 0, 0);
    xf(0, 8'h1c, 0);
    chk("mode34", 32'h5aa5, q);
    xf(0, 8'h04, 0);
    chk("slverr", 1, err);
    cfg(16'h0101, 16'h1100, 0);
    xf(1, 8'h1c, 32'hf2f2);
    xf(0, 8'h1c, 0);
    chk("locked", 32'hf1f1, q);
    for (int k = 0; k < 7; k++) begin
      cfg(tm[k], 16'h1100, tt[k]);
      pul(ti[k], 3);
      chk("ev3", x3[k], ev3);
      chk("ev4", x4[k], ev4);
    end
    // Nonzero count so stored captures differ from the reset value
    cnt <= 16'h0abc;
    for (int p = 0; p < 4; p++) begin
      cfg(16'(16'h0101 | (p << 2) | (p << 10)), 16'h1100, 0);
      pul(1, 8);
      pul(2, 8);
      chk("psc3", 8 >> p, ev3);
      chk("psc4", 8 >> p, ev4);
    end
    for (int k = 0; k < 3; k++) begin
      cfg(16'h0101, pe[k] | (pe[k] << 4), 0);
      tin[1] <= 1;
      repeat (12) @(posedge pclk);
      chk("rise", xr[k], ev3);
      chk("level", xr[k] == 1 ? 2'b10 : 2'b01, {ci3, ci4});
      tin[1] <= 0;
      repeat (12) @(posedge pclk);
      chk("fall", xd[k], ev3);
    end
    xf(0, 8'h3c, 0);
    chk("cap3", 32'h0abc, q);
    xf(0, 8'h40, 0);
    chk("cap4", 32'h0abc, q);
    xf(1, 8'h20, 0);
    xf(1, 8'h18, 0);
    for (int k = 0; k < 4; k++) begin
      xf(1, 8'h20, en1[k]);
      r1 <= rf[k];
      repeat (3) @(posedge pclk);
      chk("out1", xo[k], {oe1, o1});
    end
    xf(1, 8'h20, 0);
    xf(1, 8'h18, 1);
    cnt <= 16'h1234;
    ev1 = 0;
    pul(0, 1);
    chk("ev1", 0, ev1);
    xf(1, 8'h20, 1);
    pul(0, 1);
    chk("ev1", 1, ev1);
    xf(0, 8'h34, 0);
    chk("cap1", 32'h1234, q);
    xf(1, 8'h18, 0);
    xf(0, 8'h18, 0);
    chk("ch1sel", 1, q);
    xf(1, 8'h20, 3);
    repeat (3) @(posedge pclk);
    chk("fp1", 1, fp1);
    xf(0, 8'h10, 0);
    chk("status", 32'h37, q);
    xf(1, 8'h10, 0);
    xf(0, 8'h10, 0);
    chk("status", 0, q);
    give_verdict;
  end
endmodule // tcc_channel_config_test
